// ---- lsr_consts.vh ----
// Constants of the light sensor register port: addresses, fields, resets, codes
`ifndef LSR_CONSTS_VH
`define LSR_CONSTS_VH

// Serial bus addresses (7-bit)
`define LSR_BUS_ADDR_PRI     7'h29
`define LSR_BUS_ADDR_SEC     7'h28

// Register indices
`define LSR_IDX_ENABLE       5'h00
`define LSR_IDX_SETUP        5'h01
`define LSR_IDX_FLT_LO_L     5'h04
`define LSR_IDX_FLT_LO_H     5'h05
`define LSR_IDX_FLT_HI_L     5'h06
`define LSR_IDX_FLT_HI_H     5'h07
`define LSR_IDX_UFL_LO_L     5'h08
`define LSR_IDX_UFL_LO_H     5'h09
`define LSR_IDX_UFL_HI_L     5'h0A
`define LSR_IDX_UFL_HI_H     5'h0B
`define LSR_IDX_PERSIST      5'h0C
`define LSR_IDX_PKG_ID       5'h11
`define LSR_IDX_DEV_ID       5'h12
`define LSR_IDX_STATUS       5'h13
`define LSR_IDX_CH0_L        5'h14
`define LSR_IDX_CH0_H        5'h15
`define LSR_IDX_CH1_L        5'h16
`define LSR_IDX_CH1_H        5'h17

// First index of a block read at the secondary address
`define LSR_SEC_BASE_IDX     5'h13

// Reset values
`define LSR_RST_BYTE         8'h00
`define LSR_RST_PTR          5'h00

// Identification values (arbitrary)
`define LSR_PKG_ID_VAL       8'h5A
`define LSR_DEV_ID_VAL       8'hA5

// Command byte fields
`define LSR_CMD_SEL_BIT      7
`define LSR_CMD_TYPE_MSB     6
`define LSR_CMD_TYPE_LSB     5
`define LSR_CMD_FIELD_MSB    4
`define LSR_CMD_FIELD_LSB    0
`define LSR_TYPE_NORMAL      2'b01
`define LSR_TYPE_SPECIAL     2'b11

// Special function codes
`define LSR_SF_FORCE_INT     5'b00100
`define LSR_SF_CLR_FILT      5'b00110
`define LSR_SF_CLR_BOTH      5'b00111
`define LSR_SF_CLR_UNFILT    5'b01010

// Status and enable bit positions
`define LSR_ST_VALID_BIT     0
`define LSR_ST_FILT_BIT      4
`define LSR_ST_UNFILT_BIT    5
`define LSR_EN_FILT_IEN_BIT  4
`define LSR_EN_UNFILT_IEN_BIT 7

`endif

// ---- lsr_line_edges.v ----
// Edge and bus condition detector for the serial clock and data lines
`timescale 1ns/100ps
`include "lsr_consts.vh"

module lsr_line_edges (
	input  wire core_clk,     // System clock
	input  wire rst_n,        // Synchronous reset, active low
	input  wire scl_in,       // Serial clock level
	input  wire sda_in,       // Serial data level
	output wire scl_rise,     // Clock rose this cycle
	output wire scl_fall,     // Clock fell this cycle
	output wire start_det,    // Start or repeated start seen
	output wire stop_det      // Stop seen
);

	reg scl_prev_reg;         // Clock level one cycle ago
	reg sda_prev_reg;         // Data level one cycle ago

	// Previous levels; idle bus reads high
	always @(posedge core_clk) begin
		if (!rst_n) begin
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			scl_prev_reg <= scl_in;
			sda_prev_reg <= sda_in;
		end
	end

	// Data moving while clock stays high marks start or stop
	assign scl_rise  = scl_in & ~scl_prev_reg;
	assign scl_fall  = ~scl_in & scl_prev_reg;
	assign start_det = scl_in & scl_prev_reg & sda_prev_reg & ~sda_in;
	assign stop_det  = scl_in & scl_prev_reg & ~sda_prev_reg & sda_in;

endmodule

// ---- lsr_read_mux.v ----
// Read data selection over the register map
`timescale 1ns/100ps
`include "lsr_consts.vh"

module lsr_read_mux (
	input  wire [4:0] idx,            // Register index to read
	input  wire [7:0] enable_val,     // Function enable register
	input  wire [7:0] setup_val,      // Gain and time register
	input  wire [7:0] flt_lo_l_val,   // Filtered low threshold, low byte
	input  wire [7:0] flt_lo_h_val,   // Filtered low threshold, high byte
	input  wire [7:0] flt_hi_l_val,   // Filtered high threshold, low byte
	input  wire [7:0] flt_hi_h_val,   // Filtered high threshold, high byte
	input  wire [7:0] ufl_lo_l_val,   // Unfiltered low threshold, low byte
	input  wire [7:0] ufl_lo_h_val,   // Unfiltered low threshold, high byte
	input  wire [7:0] ufl_hi_l_val,   // Unfiltered high threshold, low byte
	input  wire [7:0] ufl_hi_h_val,   // Unfiltered high threshold, high byte
	input  wire [7:0] persist_val,    // Interrupt filter count
	input  wire [7:0] status_val,     // Device state flags
	input  wire [7:0] ch0_l_val,      // Channel 0 low byte
	input  wire [7:0] ch0_h_val,      // Channel 0 high byte
	input  wire [7:0] ch1_l_val,      // Channel 1 low byte
	input  wire [7:0] ch1_h_val,      // Channel 1 high byte
	output reg  [7:0] rd_data         // Selected byte
);

	// Unmapped indices read as zero
	always @* begin
		case (idx)
			`LSR_IDX_ENABLE:   rd_data = enable_val;
			`LSR_IDX_SETUP:    rd_data = setup_val;
			`LSR_IDX_FLT_LO_L: rd_data = flt_lo_l_val;
			`LSR_IDX_FLT_LO_H: rd_data = flt_lo_h_val;
			`LSR_IDX_FLT_HI_L: rd_data = flt_hi_l_val;
			`LSR_IDX_FLT_HI_H: rd_data = flt_hi_h_val;
			`LSR_IDX_UFL_LO_L: rd_data = ufl_lo_l_val;
			`LSR_IDX_UFL_LO_H: rd_data = ufl_lo_h_val;
			`LSR_IDX_UFL_HI_L: rd_data = ufl_hi_l_val;
			`LSR_IDX_UFL_HI_H: rd_data = ufl_hi_h_val;
			`LSR_IDX_PERSIST:  rd_data = persist_val;
			`LSR_IDX_PKG_ID:   rd_data = `LSR_PKG_ID_VAL;
			`LSR_IDX_DEV_ID:   rd_data = `LSR_DEV_ID_VAL;
			`LSR_IDX_STATUS:   rd_data = status_val;
			`LSR_IDX_CH0_L:    rd_data = ch0_l_val;
			`LSR_IDX_CH0_H:    rd_data = ch0_h_val;
			`LSR_IDX_CH1_L:    rd_data = ch1_l_val;
			`LSR_IDX_CH1_H:    rd_data = ch1_h_val;
			default:           rd_data = 8'h00;
		endcase
	end

endmodule

// ---- lsr_register_port.v ----
// Serial-bus register bank of the light sensor: slave engine, command pointer, registers
`timescale 1ns/100ps
`include "lsr_consts.vh"

module lsr_register_port (
	input  wire        core_clk,        // System clock, 50 MHz
	input  wire        rst_n,           // Synchronous reset, active low
	input  wire        scl_in,          // Serial clock line level
	input  wire        sda_in,          // Serial data line level
	output wire        sda_out,         // Serial data drive value, always low
	output wire        sda_oe,          // Serial data drive enable
	input  wire        result_load,     // Core pulse: new channel results
	input  wire [15:0] ch0_result,      // Broadband channel count
	input  wire [15:0] ch1_result,      // Infrared channel count
	input  wire        filt_int_evt,    // Core pulse: filtered threshold event
	input  wire        unfilt_int_evt,  // Core pulse: unfiltered threshold event
	output wire [7:0]  enable_ctrl,     // Function enable register value
	output wire [7:0]  setup_ctrl,      // Gain and time register value
	output wire [15:0] filt_low_thr,    // Filtered low threshold
	output wire [15:0] filt_high_thr,   // Filtered high threshold
	output wire [15:0] unfilt_low_thr,  // Unfiltered low threshold
	output wire [15:0] unfilt_high_thr, // Unfiltered high threshold
	output wire [7:0]  filter_count,    // Interrupt filter count
	output reg         int_n            // Interrupt pin, active low
);

	// Slave engine states
	localparam ST_IDLE    = 3'd0;     // Not addressed
	localparam ST_ADDR    = 3'd1;     // Shifting address byte
	localparam ST_ADDR_AK = 3'd2;     // Driving address acknowledge
	localparam ST_WR      = 3'd3;     // Shifting a written byte
	localparam ST_WR_AK   = 3'd4;     // Driving write acknowledge
	localparam ST_RD      = 3'd5;     // Sending a read byte
	localparam ST_RD_AK   = 3'd6;     // Sampling host acknowledge
	localparam ST_RD_NXT  = 3'd7;     // Acknowledged, next byte at clock fall

	// Line events
	wire       scl_rise;              // Clock rising edge
	wire       scl_fall;              // Clock falling edge
	wire       start_det;             // Start condition
	wire       stop_det;              // Stop condition

	// Engine state
	reg  [2:0] state_reg;             // Engine state
	reg  [3:0] bit_cnt_reg;           // Bits shifted or sent
	reg  [7:0] shift_reg;             // Received byte
	reg  [7:0] tx_reg;                // Byte being sent, MSB first
	reg        sda_oe_reg;            // Data line pulled low
	reg        read_dir_reg;          // Transaction is a read
	reg        sec_addr_reg;          // Addressed at secondary address
	reg        first_byte_reg;        // Next written byte may be a command
	reg  [4:0] offs_reg;              // Byte offset inside a transaction
	reg  [4:0] ptr_reg;               // Stored register pointer

	// Register bank
	reg  [7:0] enable_reg;            // Function enable
	reg  [7:0] setup_reg;             // Gain and integration time
	reg  [7:0] flt_lo_l_reg;          // Filtered low threshold low byte
	reg  [7:0] flt_lo_h_reg;          // Filtered low threshold high byte
	reg  [7:0] flt_hi_l_reg;          // Filtered high threshold low byte
	reg  [7:0] flt_hi_h_reg;          // Filtered high threshold high byte
	reg  [7:0] ufl_lo_l_reg;          // Unfiltered low threshold low byte
	reg  [7:0] ufl_lo_h_reg;          // Unfiltered low threshold high byte
	reg  [7:0] ufl_hi_l_reg;          // Unfiltered high threshold low byte
	reg  [7:0] ufl_hi_h_reg;          // Unfiltered high threshold high byte
	reg  [7:0] persist_reg;           // Interrupt filter count
	reg  [15:0] ch0_reg;              // Channel 0 result
	reg  [15:0] ch1_reg;              // Channel 1 result
	reg        valid_reg;             // Results loaded since reset
	reg        filt_flag_reg;         // Filtered interrupt pending
	reg        unfilt_flag_reg;       // Unfiltered interrupt pending

	// Decode helpers
	wire       byte_done;             // Eighth written bit closed by clock fall
	wire       is_cmd;                // Completed byte is a command byte
	wire [1:0] cmd_type;              // Transaction type of command byte
	wire [4:0] cmd_field;             // Index or function field
	wire       cmd_stb;               // Command byte accepted
	wire       wr_stb;                // Data byte write
	wire [4:0] acc_idx;               // Register index of current byte
	wire [7:0] rd_data;               // Byte read at acc_idx
	wire [7:0] status_val;            // Status byte
	wire       sf_force;              // Force interrupt
	wire       sf_clr_filt;           // Clear filtered interrupt
	wire       sf_clr_unfilt;         // Clear unfiltered interrupt
	wire       addr_hit;              // Address byte matches and may be served

	// Serial bus condition detector
	lsr_line_edges u_edges (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.scl_in    (scl_in),
		.sda_in    (sda_in),
		.scl_rise  (scl_rise),
		.scl_fall  (scl_fall),
		.start_det (start_det),
		.stop_det  (stop_det)
	);

	// Read data selection
	lsr_read_mux u_mux (
		.idx          (acc_idx),
		.enable_val   (enable_reg),
		.setup_val    (setup_reg),
		.flt_lo_l_val (flt_lo_l_reg),
		.flt_lo_h_val (flt_lo_h_reg),
		.flt_hi_l_val (flt_hi_l_reg),
		.flt_hi_h_val (flt_hi_h_reg),
		.ufl_lo_l_val (ufl_lo_l_reg),
		.ufl_lo_h_val (ufl_lo_h_reg),
		.ufl_hi_l_val (ufl_hi_l_reg),
		.ufl_hi_h_val (ufl_hi_h_reg),
		.persist_val  (persist_reg),
		.status_val   (status_val),
		.ch0_l_val    (ch0_reg[7:0]),
		.ch0_h_val    (ch0_reg[15:8]),
		.ch1_l_val    (ch1_reg[7:0]),
		.ch1_h_val    (ch1_reg[15:8]),
		.rd_data      (rd_data)
	);

	// Secondary address serves reads only, from the read-only block
	assign addr_hit = (shift_reg[7:1] == `LSR_BUS_ADDR_PRI) |
		((shift_reg[7:1] == `LSR_BUS_ADDR_SEC) & shift_reg[0]);

	// Access index: stored pointer plus offset, or the read-only block base
	assign acc_idx = sec_addr_reg ? (`LSR_SEC_BASE_IDX + offs_reg) : (ptr_reg + offs_reg);

	// Written byte classification
	assign byte_done = (state_reg == ST_WR) & scl_fall & (bit_cnt_reg == 4'd8);
	assign is_cmd    = first_byte_reg & shift_reg[`LSR_CMD_SEL_BIT];
	assign cmd_type  = shift_reg[`LSR_CMD_TYPE_MSB:`LSR_CMD_TYPE_LSB];
	assign cmd_field = shift_reg[`LSR_CMD_FIELD_MSB:`LSR_CMD_FIELD_LSB];
	assign cmd_stb   = byte_done & is_cmd;
	assign wr_stb    = byte_done & ~is_cmd;

	// Special function decode; each acts in the cycle it is accepted
	assign sf_force      = cmd_stb & (cmd_type == `LSR_TYPE_SPECIAL) &
		(cmd_field == `LSR_SF_FORCE_INT);
	assign sf_clr_filt   = cmd_stb & (cmd_type == `LSR_TYPE_SPECIAL) &
		((cmd_field == `LSR_SF_CLR_FILT) | (cmd_field == `LSR_SF_CLR_BOTH));
	assign sf_clr_unfilt = cmd_stb & (cmd_type == `LSR_TYPE_SPECIAL) &
		((cmd_field == `LSR_SF_CLR_UNFILT) | (cmd_field == `LSR_SF_CLR_BOTH));

	// Status byte built from live flags
	assign status_val = {2'b00, unfilt_flag_reg, filt_flag_reg, 3'b000, valid_reg};

	// Open-drain data: only ever pull low
	assign sda_out = 1'b0;
	assign sda_oe  = sda_oe_reg;

	// Slave engine
	always @(posedge core_clk) begin
		if (!rst_n) begin
			state_reg      <= ST_IDLE;
			bit_cnt_reg    <= 4'd0;
			shift_reg      <= 8'h00;
			tx_reg         <= 8'h00;
			sda_oe_reg     <= 1'b0;
			read_dir_reg   <= 1'b0;
			sec_addr_reg   <= 1'b0;
			first_byte_reg <= 1'b0;
			offs_reg       <= 5'd0;
		end else if (start_det) begin
			// Start or repeated start restarts address phase
			state_reg      <= ST_ADDR;
			bit_cnt_reg    <= 4'd0;
			sda_oe_reg     <= 1'b0;
			sec_addr_reg   <= 1'b0;
			first_byte_reg <= 1'b1;
			offs_reg       <= 5'd0;
		end else if (stop_det) begin
			// Stop always frees the line
			state_reg  <= ST_IDLE;
			sda_oe_reg <= 1'b0;
		end else begin
			case (state_reg)
				ST_ADDR, ST_WR: begin
					// Sample data on clock rise
					if (scl_rise) begin
						shift_reg   <= {shift_reg[6:0], sda_in};
						bit_cnt_reg <= bit_cnt_reg + 4'd1;
					end else if (scl_fall && bit_cnt_reg == 4'd8) begin
						if (state_reg == ST_WR) begin
							// Acknowledge every written byte
							sda_oe_reg     <= 1'b1;
							state_reg      <= ST_WR_AK;
							first_byte_reg <= 1'b0;
							if (!is_cmd) begin
								offs_reg <= offs_reg + 5'd1;
							end
						end else if (addr_hit) begin
							// Our address: acknowledge it
							sda_oe_reg   <= 1'b1;
							state_reg    <= ST_ADDR_AK;
							read_dir_reg <= shift_reg[0];
							sec_addr_reg <= (shift_reg[7:1] == `LSR_BUS_ADDR_SEC);
						end else begin
							// Not ours: stay off the line until next start
							state_reg <= ST_IDLE;
						end
					end
				end
				ST_ADDR_AK, ST_RD_NXT: begin
					// End of acknowledge bit: begin data phase
					if (scl_fall) begin
						bit_cnt_reg <= 4'd0;
						if (read_dir_reg) begin
							tx_reg      <= {rd_data[6:0], 1'b0};
							sda_oe_reg  <= ~rd_data[7];
							bit_cnt_reg <= 4'd1;
							state_reg   <= ST_RD;
						end else begin
							sda_oe_reg <= 1'b0;
							state_reg  <= ST_WR;
						end
					end
				end
				ST_WR_AK: begin
					// Release after acknowledge bit
					if (scl_fall) begin
						sda_oe_reg  <= 1'b0;
						bit_cnt_reg <= 4'd0;
						state_reg   <= ST_WR;
					end
				end
				ST_RD: begin
					// Shift next bit out on clock fall
					if (scl_fall) begin
						if (bit_cnt_reg == 4'd8) begin
							sda_oe_reg <= 1'b0;
							offs_reg   <= offs_reg + 5'd1;
							state_reg  <= ST_RD_AK;
						end else begin
							sda_oe_reg  <= ~tx_reg[7];
							tx_reg      <= {tx_reg[6:0], 1'b0};
							bit_cnt_reg <= bit_cnt_reg + 4'd1;
						end
					end
				end
				ST_RD_AK: begin
					// Host not acknowledging ends the read
					if (scl_rise) begin
						state_reg <= sda_in ? ST_IDLE : ST_RD_NXT;
					end
				end
				default: begin
					state_reg  <= ST_IDLE;
					sda_oe_reg <= 1'b0;
				end
			endcase
		end
	end

	// Stored pointer; only a normal command byte moves it
	always @(posedge core_clk) begin
		if (!rst_n) begin
			ptr_reg <= `LSR_RST_PTR;
		end else if (cmd_stb && cmd_type == `LSR_TYPE_NORMAL) begin
			ptr_reg <= cmd_field;
		end
	end

	// Read-write registers; read-only indices fall to default
	always @(posedge core_clk) begin
		if (!rst_n) begin
			enable_reg   <= `LSR_RST_BYTE;
			setup_reg    <= `LSR_RST_BYTE;
			flt_lo_l_reg <= `LSR_RST_BYTE;
			flt_lo_h_reg <= `LSR_RST_BYTE;
			flt_hi_l_reg <= `LSR_RST_BYTE;
			flt_hi_h_reg <= `LSR_RST_BYTE;
			ufl_lo_l_reg <= `LSR_RST_BYTE;
			ufl_lo_h_reg <= `LSR_RST_BYTE;
			ufl_hi_l_reg <= `LSR_RST_BYTE;
			ufl_hi_h_reg <= `LSR_RST_BYTE;
			persist_reg  <= `LSR_RST_BYTE;
		end else if (wr_stb) begin
			case (acc_idx)
				`LSR_IDX_ENABLE:   enable_reg   <= shift_reg;
				`LSR_IDX_SETUP:    setup_reg    <= shift_reg;
				`LSR_IDX_FLT_LO_L: flt_lo_l_reg <= shift_reg;
				`LSR_IDX_FLT_LO_H: flt_lo_h_reg <= shift_reg;
				`LSR_IDX_FLT_HI_L: flt_hi_l_reg <= shift_reg;
				`LSR_IDX_FLT_HI_H: flt_hi_h_reg <= shift_reg;
				`LSR_IDX_UFL_LO_L: ufl_lo_l_reg <= shift_reg;
				`LSR_IDX_UFL_LO_H: ufl_lo_h_reg <= shift_reg;
				`LSR_IDX_UFL_HI_L: ufl_hi_l_reg <= shift_reg;
				`LSR_IDX_UFL_HI_H: ufl_hi_h_reg <= shift_reg;
				`LSR_IDX_PERSIST:  persist_reg  <= shift_reg;
				default: begin
					// Read-only or unmapped: ignore the byte
					enable_reg <= enable_reg;
				end
			endcase
		end
	end

	// Channel results: loaded by the core only, never by the host
	always @(posedge core_clk) begin
		if (!rst_n) begin
			ch0_reg   <= 16'h0000;
			ch1_reg   <= 16'h0000;
			valid_reg <= 1'b0;
		end else if (result_load) begin
			ch0_reg   <= ch0_result;
			ch1_reg   <= ch1_result;
			valid_reg <= 1'b1;
		end
	end

	// Interrupt flags: an event in the clearing cycle wins over the clear
	always @(posedge core_clk) begin
		if (!rst_n) begin
			filt_flag_reg   <= 1'b0;
			unfilt_flag_reg <= 1'b0;
		end else begin
			if (filt_int_evt || sf_force) begin
				filt_flag_reg <= 1'b1;
			end else if (sf_clr_filt) begin
				filt_flag_reg <= 1'b0;
			end
			if (unfilt_int_evt) begin
				unfilt_flag_reg <= 1'b1;
			end else if (sf_clr_unfilt) begin
				unfilt_flag_reg <= 1'b0;
			end
		end
	end

	// Interrupt pin shows flags only where their enable bit is set
	always @(posedge core_clk) begin
		if (!rst_n) begin
			int_n <= 1'b1;
		end else begin
			int_n <= ~((filt_flag_reg & enable_reg[`LSR_EN_FILT_IEN_BIT]) |
				(unfilt_flag_reg & enable_reg[`LSR_EN_UNFILT_IEN_BIT]));
		end
	end

	// Register values toward the core
	assign enable_ctrl     = enable_reg;
	assign setup_ctrl      = setup_reg;
	assign filt_low_thr    = {flt_lo_h_reg, flt_lo_l_reg};
	assign filt_high_thr   = {flt_hi_h_reg, flt_hi_l_reg};
	assign unfilt_low_thr  = {ufl_lo_h_reg, ufl_lo_l_reg};
	assign unfilt_high_thr = {ufl_hi_h_reg, ufl_hi_l_reg};
	assign filter_count    = persist_reg;

endmodule

// ---- lsr_register_port_assertions.sv ----
// Port checker of the light sensor register port
`timescale 1ns/100ps
module lsr_port_checker (
	input wire        core_clk,        // System clock
	input wire        rst_n,           // Synchronous reset, active low
	input wire        scl_in,          // Serial clock level
	input wire        sda_out,         // Data drive value
	input wire        sda_oe,          // Data drive enable
	input wire [7:0]  enable_ctrl,     // Enable register
	input wire [7:0]  setup_ctrl,      // Gain and time register
	input wire [15:0] filt_low_thr,    // Filtered low threshold
	input wire [15:0] unfilt_high_thr, // Unfiltered high threshold
	input wire [7:0]  filter_count,    // Interrupt filter count
	input wire        int_n            // Interrupt, active low
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	// Control bytes and pins leave reset cleared
	property p_rst_ctrl;
		$rose(rst_n) |-> enable_ctrl == 8'h00 && setup_ctrl == 8'h00 && !sda_oe && int_n;
	endproperty
	a_rst_ctrl: assert property (p_rst_ctrl) else $error("control not cleared");
	// Filtered low and unfiltered high thresholds and filter count leave reset cleared
	property p_rst_thr;
		$rose(rst_n) |-> filt_low_thr == 16'h0000 && unfilt_high_thr == 16'h0000
			&& filter_count == 8'h00;
	endproperty
	a_rst_thr: assert property (p_rst_thr) else $error("threshold not cleared");
	// Open drain: pulls only low, releases in clock low
	property p_drive_low;
		$fell(sda_oe) |-> !scl_in && !sda_out;
	endproperty
	a_drive_low: assert property (p_drive_low) else $error("data freed in clock high");
	// Pull-down starts only while the clock is low
	property p_oe_rise;
		$rose(sda_oe) |-> !scl_in && !$past(scl_in);
	endproperty
	a_oe_rise: assert property (p_oe_rise) else $error("data pulled in clock high");
	// Driven data stays put for three cycles after a clock rise
	property p_oe_steady;
		$rose(scl_in) |-> $stable(sda_oe) [*3];
	endproperty
	a_oe_steady: assert property (p_oe_steady) else $error("data moved in clock high");
	// Register contents change only at byte ends, clock low
	property p_write_low;
		$past(rst_n) && !$stable({enable_ctrl, setup_ctrl, filt_low_thr, unfilt_high_thr,
			filter_count}) |-> !scl_in && !$past(scl_in);
	endproperty
	a_write_low: assert property (p_write_low) else $error("register changed off byte");
	// No interrupt pin while both enables are off
	property p_int_masked;
		(!enable_ctrl[4] && !enable_ctrl[7]) [*2] |-> int_n;
	endproperty
	a_int_masked: assert property (p_int_masked) else $error("interrupt while masked");
	// Interrupt clears land at a command byte end
	property p_int_clear;
		$rose(int_n) |-> !scl_in;
	endproperty
	a_int_clear: assert property (p_int_clear) else $error("interrupt cleared off byte");
endmodule

bind lsr_register_port lsr_port_checker chk_u (.core_clk, .rst_n, .scl_in, .sda_out, .sda_oe,
	.enable_ctrl, .setup_ctrl, .filt_low_thr, .unfilt_high_thr, .filter_count, .int_n);

// ---- lsr_host_model.sv ----
// Serial bus host model that drives the register port
`timescale 1ns/100ps
module lsr_host_model (
	input  wire  core_clk, // System clock
	input  wire  sda_in,   // Resolved data line
	output logic scl_line, // Clock drive, idles high
	output logic sda_pull  // High pulls data low
);
	int q = 4; // Core cycles per quarter bit; bench may slow it
	// Bus idles released
	initial begin
		scl_line = 1'b1;
		sda_pull = 1'b0;
	end
	// Quarter bit wait
	task qw;
		repeat (q) @(posedge core_clk);
	endtask
	// One bit each way; data moves only while the clock is low
	task bitx(input logic b, output logic r);
		sda_pull <= !b;
		qw();
		scl_line <= 1'b1;
		qw();
		r = sda_in;
		qw();
		scl_line <= 1'b0;
		qw();
	endtask
	// Start or repeated start, then clock low
	task start;
		sda_pull <= 1'b0;
		qw();
		scl_line <= 1'b1;
		qw();
		sda_pull <= 1'b1;
		qw();
		scl_line <= 1'b0;
		qw();
	endtask
	// Stop: data rises with the clock high
	task stop;
		sda_pull <= 1'b1;
		qw();
		scl_line <= 1'b1;
		qw();
		sda_pull <= 1'b0;
		qw();
	endtask
	// Eight bits msb first plus the answer bit
	task xbyte(input logic [7:0] d, input logic ab, output logic [7:0] r, output logic a);
		for (int i = 7; i >= 0; i--)
			bitx(d[i], r[i]);
		bitx(ab, a);
	endtask
	// Address, command byte and optional data byte; k holds raw answer bits
	task wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
		input logic two, output logic [2:0] k);
		logic [7:0] r;
		k = 3'h0;
		start();
		xbyte({a, 1'b0}, 1'b1, r, k[2]);
		xbyte(c, 1'b1, r, k[1]);
		if (two)
			xbyte(d, 1'b1, r, k[0]);
		stop();
	endtask
	// Read n bytes at address a, from the stored pointer at the primary address; last byte gets no acknowledge
	task rd(input logic [6:0] a, input int n, output logic [39:0] v);
		logic [7:0] r;
		logic       k;
		v = 40'h0;
		start();
		xbyte({a, 1'b1}, 1'b1, r, k);
		for (int i = 1; i <= n; i++) begin
			xbyte(8'hFF, i == n, r, k);
			v = {v[31:0], r};
		end
		stop();
	endtask
endmodule

// ---- lsr_register_port_bench.sv ----
// Self-checking bench of the light sensor register port
`timescale 1ns/100ps
`include "lsr_consts.vh"
module lsr_register_port_bench;
	logic        core_clk = 1'b0;       // System clock
	logic        rst_n = 1'b0;          // Reset, active low
	logic        result_load = 1'b0;    // New results pulse
	logic [15:0] ch0_result = 16'h0000; // Broadband count
	logic [15:0] ch1_result = 16'h0000; // Infrared count
	logic        filt_int_evt = 1'b0;   // Filtered event pulse
	logic        unfilt_int_evt = 1'b0; // Unfiltered event pulse
	wire         scl_line;              // Host clock
	wire         sda_pull;              // Host pulls data low
	wire         sda_out;               // Device drive value
	wire         sda_oe;                // Device pulls data low
	wire         sda;                   // Wired data line, pulled up
	wire  [7:0]  enable_ctrl;           // Register outputs
	wire  [7:0]  setup_ctrl;
	wire  [7:0]  filter_count;
	wire  [15:0] filt_low_thr;
	wire  [15:0] filt_high_thr;
	wire  [15:0] unfilt_low_thr;
	wire  [15:0] unfilt_high_thr;
	wire         int_n;                 // Interrupt, active low
	int          errors = 0;            // Mismatches
	int          n_checks = 0;          // Comparisons
	logic [39:0] v;                     // Read bytes, last in low byte
	logic [2:0]  k;                     // Answer bits, 0 is acknowledge

	assign sda = !(sda_pull || (sda_oe && !sda_out));
	// 50 MHz clock
	always #10 core_clk = !core_clk;

	lsr_register_port dut_u (.*, .scl_in(scl_line), .sda_in(sda));
	lsr_host_model host_u (.core_clk, .sda_in(sda), .scl_line, .sda_pull);

	// Distinct byte per register index
	function automatic logic [7:0] pat(input int i);
		return {i[3:0], ~i[3:0]};
	endfunction
	// Compare and count
	task check(input string name, input logic [47:0] seen, input logic [47:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Counts, verdict, end of run
	task results;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Point at a register and write one byte
	task put(input int i, input logic [7:0] d);
		host_u.wr(`LSR_BUS_ADDR_PRI, {3'b101, i[4:0]}, d, 1'b1, k);
		check("write answer", k, 3'h0);
	endtask
	// Point at a register and read n bytes
	task get(input int i, input int n);
		host_u.wr(`LSR_BUS_ADDR_PRI, {3'b101, i[4:0]}, 8'h00, 1'b0, k);
		host_u.rd(`LSR_BUS_ADDR_PRI, n, v);
	endtask
	// Special function command
	task sf(input logic [4:0] c);
		host_u.wr(`LSR_BUS_ADDR_PRI, {3'b111, c}, 8'h00, 1'b0, k);
	endtask
	// Core event pulses, then let flags reach the pin
	task evt(input logic f, input logic u);
		filt_int_evt <= f;
		unfilt_int_evt <= u;
		@(posedge core_clk);
		filt_int_evt <= 1'b0;
		unfilt_int_evt <= 1'b0;
		repeat (3) @(posedge core_clk);
	endtask

	// Hang guard
	initial begin
		repeat (100000) @(posedge core_clk);
		errors++;
		results();
	end

	// Main sequence
	initial begin
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		for (int i = 0; i < 13; i++) begin
			if (i == 2 || i == 3)
				continue;
			get(i, 1);
			check("reset value", v, 40'h0);
			put(i, pat(i));
		end
		for (int i = 0; i < 13; i++) begin
			if (i == 2 || i == 3)
				continue;
			get(i, 1);
			check("read back", v, pat(i));
		end
		check("filtered out", {filt_low_thr, filt_high_thr}, {pat(5), pat(4), pat(7), pat(6)});
		check("unfiltered out", {unfilt_low_thr, unfilt_high_thr},
			{pat(9), pat(8), pat(11), pat(10)});
		check("control out", {enable_ctrl, setup_ctrl, filter_count}, {pat(0), pat(1), pat(12)});
		$display("test register map done");
		// Slow host: stored pointer, special commands
		host_u.q = 7;
		get(6, 2);
		check("two byte read", v, {pat(6), pat(7)});
		sf(`LSR_SF_CLR_UNFILT);
		sf(`LSR_SF_CLR_BOTH);
		host_u.rd(`LSR_BUS_ADDR_PRI, 1, v);
		check("stored pointer", v, pat(6));
		host_u.q = 4;
		$display("test pointer done");
		// Results, read-only bytes, secondary address
		ch0_result <= 16'hBEEF;
		ch1_result <= 16'h1234;
		result_load <= 1'b1;
		@(posedge core_clk);
		result_load <= 1'b0;
		put(5'h14, 8'h55);
		put(5'h13, 8'hFF);
		get(5'h14, 4);
		check("channel bytes", v, 40'hEFBE3412);
		get(5'h11, 2);
		check("ident bytes", v, {`LSR_PKG_ID_VAL, `LSR_DEV_ID_VAL});
		host_u.rd(`LSR_BUS_ADDR_SEC, 5, v);
		check("secondary block", v, 40'h01EFBE3412);
		host_u.wr(`LSR_BUS_ADDR_SEC, 8'hA0, 8'h00, 1'b0, k);
		check("secondary write", k[2], 1'b1);
		host_u.wr(7'h30, 8'hA0, 8'h00, 1'b0, k);
		check("foreign address", k[2], 1'b1);
		$display("test results done");
		// Special functions
		put(5'h00, 8'h90);
		sf(`LSR_SF_FORCE_INT);
		check("forced pin", int_n, 1'b0);
		get(5'h13, 1);
		check("forced status", v, 40'h11);
		sf(`LSR_SF_CLR_FILT);
		check("filtered clear", int_n, 1'b1);
		evt(1'b0, 1'b1);
		sf(`LSR_SF_CLR_FILT);
		check("wrong clear", int_n, 1'b0);
		sf(`LSR_SF_CLR_UNFILT);
		check("unfiltered clear", int_n, 1'b1);
		evt(1'b1, 1'b1);
		get(5'h13, 1);
		check("both flags", v, 40'h31);
		sf(`LSR_SF_CLR_BOTH);
		check("both clear", int_n, 1'b1);
		get(5'h13, 1);
		check("cleared status", v, 40'h01);
		$display("test special functions done");
		// Reset in mid-run
		rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		check("second reset", {enable_ctrl, filt_low_thr, int_n}, 25'h1);
		$display("test second reset done");
		results();
	end
endmodule
